// File: verilog/pmem_table_pkg.sv
/*
 Shared constants and carriers for the program memory access unit:
 word and page geometry, reset vector, serial frame layout, and the
 table read request and data memory write-back structs.
 Assumes one core clock where one clock equals one instruction cycle.
*/
package pmem_table_pkg;
    // Memory geometry
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int MAX_ADDR_W = 13;
    localparam int PAGE_W = 8;
    localparam int HIGH_PTR_W = MAX_ADDR_W - PAGE_W;
    localparam int CNT_W = 5;
    // Reset vector word address
    localparam logic [MAX_ADDR_W-1:0] RESET_VECTOR = 13'h0000;
    // Serial frame: one direction bit, address bits, then a data word
    localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;
    localparam logic [CNT_W-1:0] WORD_LAST = 5'h0f;
    localparam logic SER_DIR_READ = 1'b1;
    // Synchroniser vector bit positions
    localparam int PIN_EN = 0;
    localparam int PIN_SEL = 1;
    localparam int PIN_PCLK = 2;
    localparam int PIN_PDAT = 3;
    localparam int PIN_DCLK = 4;
    localparam int PIN_DDAT = 5;
    localparam int PIN_N = 6;

    // Table read request from the execute stage
    typedef struct packed {
        logic req;
        logic current_page;
        logic [BYTE_W-1:0] dest;
        logic [BYTE_W-1:0] ptr_low;
        logic [HIGH_PTR_W-1:0] table_pointer_high;
    } tbl_req_t;

    // Data memory write-back of the low table byte
    typedef struct packed {
        logic en;
        logic [BYTE_W-1:0] addr;
        logic [BYTE_W-1:0] data;
    } dm_wr_t;

    typedef enum logic {ST_FETCH, ST_TABLE} acc_state_t;
    typedef enum logic [1:0] {SER_IDLE, SER_ADDR, SER_WDATA, SER_RDATA} ser_state_t;
endpackage

// File: verilog/program_memory_table_read.sv
/*
 Program memory access unit: instruction fetch, table reads with a
 pointer pair or a current-page offset, the read-only high byte holder,
 and a serial port for programming and debug access to the array.
 Assumes the core holds pc_addr stable while a
 table read is pending, and keeps the core idle while serial writes run.
*/
// Contract
// - Program memory holds 16-bit words, up to 8K words, sized 2K, 4K or 8K per variant.
// - Fetches are addressed by the program counter and table data by the table pointers.
// - After reset the first fetch is from word address zero, the reset vector.
// - A table read may address any program memory word.
// - The table address is the high pointer joined to the low pointer.
// - A table read writes the low byte of the word to the data register named by the operand.
// - A table read loads the upper part of the word into the high byte holder, unused bits zero.
// - The current-page read offsets the low pointer from the start of the executing page.
// - The high byte holder cannot be written by software.
// - Every table read takes exactly two instruction cycles.
// - Programming data moves both ways on one serial data pin clocked by the programmer.
// - The debug port has one two-way data and address pin and a clock input from the tool.
`timescale 1ns/1ns
module program_memory_table_read #(
    parameter int ADDR_W = 13 // 11, 12 or 13 for 2K, 4K or 8K words
) (
    input wire logic core_clk, // Core clock, one instruction cycle
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic [ADDR_W-1:0] pc_addr, // Program counter of next fetch
    input wire pmem_table_pkg::tbl_req_t tbl_req, // Table read request
    output logic [pmem_table_pkg::WORD_W-1:0] instr_word_q, // Fetched word
    output logic instr_valid_q, // Fetched word is valid
    output logic fetch_stall, // Program counter must hold
    output pmem_table_pkg::dm_wr_t dm_wr_q, // Low byte write-back
    output logic [pmem_table_pkg::BYTE_W-1:0] table_read_high_byte_q, // High byte holder
    input wire logic serial_enable, // Serial access enable pin
    input wire logic debug_select, // Use debug pins instead of programming pins
    input wire logic prog_serial_clock, // Programming clock from programmer
    input wire logic prog_serial_data_i, // Programming data in
    output logic prog_serial_data_o, // Programming data out
    output logic prog_serial_data_oe_n, // Low while device drives the pin
    input wire logic debug_clock_in, // Debug clock from debug tool
    input wire logic debug_data_addr_i, // Debug data and address in
    output logic debug_data_addr_o, // Debug data out
    output logic debug_data_addr_oe_n // Low while device drives the pin
);
    localparam int WW = pmem_table_pkg::WORD_W;
    localparam int BW = pmem_table_pkg::BYTE_W;
    localparam int PW = pmem_table_pkg::PAGE_W;
    localparam int HW = pmem_table_pkg::HIGH_PTR_W;
    localparam logic [pmem_table_pkg::CNT_W-1:0] ADDR_LAST = 5'(ADDR_W - 1);

    // Word array, sized by the variant's address width
    logic [WW-1:0] mem [0:(1 << ADDR_W)-1];

    pmem_table_pkg::acc_state_t state_q;
    logic first_q;
    logic page_q;
    logic [BW-1:0] dest_q;
    logic [BW-1:0] tblp_q;
    logic [HW-1:0] table_pointer_high_q;
    logic [ADDR_W-PW-1:0] pc_page_q;
    logic [ADDR_W-1:0] tbl_addr;
    logic [ADDR_W-1:0] mem_addr;
    logic [WW-1:0] rd_word;

    // Table address: pointer pair or current page plus low pointer
    always_comb begin
        if (page_q) begin
            tbl_addr = {pc_page_q, tblp_q};
        end else begin
            tbl_addr = ADDR_W'({table_pointer_high_q, tblp_q});
        end
    end

    // One read port: table address in the table cycle, else the fetch address
    always_comb begin
        if (state_q == pmem_table_pkg::ST_TABLE) begin
            mem_addr = tbl_addr;
        end else if (first_q) begin
            mem_addr = pmem_table_pkg::RESET_VECTOR[ADDR_W-1:0];
        end else begin
            mem_addr = pc_addr;
        end
    end
    assign rd_word = mem[mem_addr];

    // Fetch is held while the port serves the table word
    assign fetch_stall = (state_q == pmem_table_pkg::ST_TABLE);

    // Access sequencer: a table read spends its second cycle on the port
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= pmem_table_pkg::ST_FETCH;
        end else begin
            case (state_q)
                pmem_table_pkg::ST_FETCH: begin
                    if (tbl_req.req) begin
                        state_q <= pmem_table_pkg::ST_TABLE;
                    end
                end
                pmem_table_pkg::ST_TABLE: begin
                    state_q <= pmem_table_pkg::ST_FETCH;
                end
                default: begin
                    state_q <= pmem_table_pkg::ST_FETCH;
                end
            endcase
        end
    end

    // Reset vector flag, cleared once the first fetch has been taken
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    // Capture the request so the core may move on during the table cycle
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            page_q <= 1'b0;
            dest_q <= '0;
            tblp_q <= '0;
            table_pointer_high_q <= '0;
            pc_page_q <= '0;
        end else if (tbl_req.req && state_q == pmem_table_pkg::ST_FETCH) begin
            page_q <= tbl_req.current_page;
            dest_q <= tbl_req.dest;
            tblp_q <= tbl_req.ptr_low;
            table_pointer_high_q <= tbl_req.table_pointer_high;
            pc_page_q <= pc_addr[ADDR_W-1:PW]; // Page of the executing instruction
        end
    end

    // Instruction word register; no new word during the table cycle
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            instr_word_q <= '0;
            instr_valid_q <= 1'b0;
        end else begin
            instr_valid_q <= (state_q == pmem_table_pkg::ST_FETCH);
            if (state_q == pmem_table_pkg::ST_FETCH) begin
                instr_word_q <= rd_word;
            end
        end
    end

    // Table result: low byte to data memory, high part to the holder
    // The holder is loaded only by a table read, so software cannot alter it
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dm_wr_q <= '0;
            table_read_high_byte_q <= '0;
        end else begin
            dm_wr_q.en <= (state_q == pmem_table_pkg::ST_TABLE);
            if (state_q == pmem_table_pkg::ST_TABLE) begin
                dm_wr_q.addr <= dest_q;
                dm_wr_q.data <= rd_word[BW-1:0];
                table_read_high_byte_q <= BW'(rd_word >> BW);
            end
        end
    end

    // Serial pins: two flip-flops before any logic reads them
    logic [pmem_table_pkg::PIN_N-1:0] pins_s1_q;
    logic [pmem_table_pkg::PIN_N-1:0] pins_s2_q;
    logic sclk_prev_q;
    logic sclk;
    logic sdat;
    logic rise;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pins_s1_q <= '0;
            pins_s2_q <= '0;
            sclk_prev_q <= 1'b0;
        end else begin
            pins_s1_q <= {debug_data_addr_i, debug_clock_in, prog_serial_data_i,
                prog_serial_clock, debug_select, serial_enable};
            pins_s2_q <= pins_s1_q;
            sclk_prev_q <= sclk;
        end
    end

    // Pick the pin pair; both share one engine since the pins are never active together
    always_comb begin
        if (pins_s2_q[pmem_table_pkg::PIN_SEL]) begin
            sclk = pins_s2_q[pmem_table_pkg::PIN_DCLK];
            sdat = pins_s2_q[pmem_table_pkg::PIN_DDAT];
        end else begin
            sclk = pins_s2_q[pmem_table_pkg::PIN_PCLK];
            sdat = pins_s2_q[pmem_table_pkg::PIN_PDAT];
        end
    end
    assign rise = sclk && !sclk_prev_q;

    // Serial frame engine: direction bit, address MSB first, then a word
    pmem_table_pkg::ser_state_t ser_q;
    logic ser_rd_q;
    logic [pmem_table_pkg::CNT_W-1:0] cnt_q;
    logic [ADDR_W-1:0] ser_addr_q;
    logic [WW-1:0] shreg_q;
    logic ser_wr;
    logic [ADDR_W-1:0] addr_next;
    assign addr_next = {ser_addr_q[ADDR_W-2:0], sdat};
    assign ser_wr = rise && ser_q == pmem_table_pkg::SER_WDATA
        && cnt_q == pmem_table_pkg::WORD_LAST;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ser_q <= pmem_table_pkg::SER_IDLE;
            ser_rd_q <= 1'b0;
            cnt_q <= pmem_table_pkg::CNT_RESET;
            ser_addr_q <= '0;
            shreg_q <= '0;
        end else if (!pins_s2_q[pmem_table_pkg::PIN_EN]) begin
            ser_q <= pmem_table_pkg::SER_IDLE; // Dropping enable aborts a frame
        end else if (rise) begin
            cnt_q <= cnt_q + 5'h01;
            case (ser_q)
                pmem_table_pkg::SER_IDLE: begin
                    ser_rd_q <= (sdat == pmem_table_pkg::SER_DIR_READ);
                    cnt_q <= pmem_table_pkg::CNT_RESET;
                    ser_q <= pmem_table_pkg::SER_ADDR;
                end
                pmem_table_pkg::SER_ADDR: begin
                    ser_addr_q <= addr_next;
                    if (cnt_q == ADDR_LAST) begin
                        cnt_q <= pmem_table_pkg::CNT_RESET;
                        shreg_q <= mem[addr_next];
                        if (ser_rd_q) begin
                            ser_q <= pmem_table_pkg::SER_RDATA;
                        end else begin
                            ser_q <= pmem_table_pkg::SER_WDATA;
                        end
                    end
                end
                pmem_table_pkg::SER_WDATA: begin
                    shreg_q <= {shreg_q[WW-2:0], sdat};
                    if (cnt_q == pmem_table_pkg::WORD_LAST) begin
                        ser_q <= pmem_table_pkg::SER_IDLE;
                    end
                end
                pmem_table_pkg::SER_RDATA: begin
                    shreg_q <= {shreg_q[WW-2:0], 1'b0};
                    if (cnt_q == pmem_table_pkg::WORD_LAST) begin
                        ser_q <= pmem_table_pkg::SER_IDLE;
                    end
                end
                default: begin
                    ser_q <= pmem_table_pkg::SER_IDLE;
                end
            endcase
        end
    end

    // Array write from the serial port; no reset since it models flash contents
    always_ff @(posedge core_clk) begin
        if (ser_wr) begin
            mem[ser_addr_q] <= {shreg_q[WW-2:0], sdat};
        end
    end

    // Drive the chosen data pin only while a read word is shifted out
    // Bits change on the device's sample of the rising clock; the tool samples on falling
    assign prog_serial_data_o = shreg_q[WW-1];
    assign debug_data_addr_o = shreg_q[WW-1];
    assign prog_serial_data_oe_n = !(ser_q == pmem_table_pkg::SER_RDATA
        && !pins_s2_q[pmem_table_pkg::PIN_SEL]);
    assign debug_data_addr_oe_n = !(ser_q == pmem_table_pkg::SER_RDATA
        && pins_s2_q[pmem_table_pkg::PIN_SEL]);

    // Checks
    a_reset_vector: assert property (@(posedge core_clk) disable iff (!rstn)
        first_q |-> mem_addr == '0) else $error("first fetch not at reset vector");
    a_table_two_cyc: assert property (@(posedge core_clk) disable iff (!rstn)
        (tbl_req.req && state_q == pmem_table_pkg::ST_FETCH) |=>
        (state_q == pmem_table_pkg::ST_TABLE) ##1
        (state_q == pmem_table_pkg::ST_FETCH && dm_wr_q.en))
        else $error("table read not two cycles");
    a_fetch_stall: assert property (@(posedge core_clk) disable iff (!rstn)
        fetch_stall |-> mem_addr == tbl_addr ##1 !fetch_stall)
        else $error("stall does not serve table address");
    a_pair_addr: assert property (@(posedge core_clk) disable iff (!rstn)
        (state_q == pmem_table_pkg::ST_TABLE && !page_q) |->
        mem_addr == ADDR_W'({table_pointer_high_q, tblp_q})) else $error("pointer pair address wrong");
    a_page_addr: assert property (@(posedge core_clk) disable iff (!rstn)
        (tbl_req.req && tbl_req.current_page && state_q == pmem_table_pkg::ST_FETCH) |=>
        mem_addr[ADDR_W-1:PW] == $past(pc_addr[ADDR_W-1:PW])
        && mem_addr[PW-1:0] == $past(tbl_req.ptr_low)) else $error("page offset wrong");
    a_low_byte: assert property (@(posedge core_clk) disable iff (!rstn)
        (state_q == pmem_table_pkg::ST_TABLE) |=>
        dm_wr_q.data == $past(rd_word[BW-1:0]) && dm_wr_q.addr == $past(dest_q))
        else $error("low byte write-back wrong");
    a_high_byte: assert property (@(posedge core_clk) disable iff (!rstn)
        (state_q == pmem_table_pkg::ST_TABLE) |=>
        table_read_high_byte_q == BW'($past(rd_word) >> BW)) else $error("high byte wrong");
    a_high_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        $changed(table_read_high_byte_q) |-> dm_wr_q.en) else $error("holder changed");
    a_fetch_pc: assert property (@(posedge core_clk) disable iff (!rstn)
        (state_q == pmem_table_pkg::ST_FETCH && !first_q) |=> instr_word_q == $past(rd_word)
        && $past(mem_addr) == $past(pc_addr)) else $error("fetch not from pc");
    a_pin_drive: assert property (@(posedge core_clk) disable iff (!rstn)
        (ser_q != pmem_table_pkg::SER_RDATA) |-> prog_serial_data_oe_n
        && debug_data_addr_oe_n) else $error("pin driven outside read word");
endmodule

// File: verif/core_model.sv
/*
 Behavioural model of the core execute pipeline: it drives the fetch
 address and table read requests into the program memory access unit.
 Assumes the bench calls its tasks just after a rising core_clk edge.
*/
`timescale 1ns/1ns
module core_model #(
    parameter int ADDR_W = 13 // Program counter width
) (
    input wire logic core_clk, // Core clock, one instruction cycle
    input wire logic fetch_stall, // Hold request from the access unit
    output logic [ADDR_W-1:0] pc_addr, // Next fetch word address
    output pmem_table_pkg::tbl_req_t tbl_req // Table read request
);
    // Idle values before the first command
    initial begin
        pc_addr = '0;
        tbl_req = '0;
    end

    // Move the program counter; the core holds it while fetch is stalled
    task automatic set_pc(input logic [ADDR_W-1:0] pc);
        if (!fetch_stall) pc_addr = pc;
    endtask

    // Raise a table read; only one program thread reads tables, never a handler
    task automatic issue(input logic cur, input logic [4:0] hi, input logic [7:0] lo,
            input logic [7:0] dest, input logic [ADDR_W-1:0] pc);
        pmem_table_pkg::tbl_req_t t;
        t.current_page = cur;
        t.table_pointer_high = hi;
        t.ptr_low = lo;
        t.dest = dest;
        t.req = 1'b1;
        pc_addr = pc;
        tbl_req = t; // One update, so the request never glitches
    endtask

    // Drop the request and scramble its fields, which mean nothing without req
    task automatic drop();
        pmem_table_pkg::tbl_req_t t;
        t = ~tbl_req;
        t.req = 1'b0;
        tbl_req = t;
    endtask
endmodule

// File: verif/testbench.sv
/*
 Self-checking bench for the program memory access unit: preloads the
 array over both serial pin pairs, then checks reset vector, fetch and
 table reads. Assumes the core model drives the core side.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench;
    logic core_clk, rstn, serial_enable, debug_select, sclk, host_bit, host_en;
    logic [12:0] pc_addr;
    pmem_table_pkg::tbl_req_t tbl_req;
    pmem_table_pkg::dm_wr_t dm_wr_q;
    logic [15:0] instr_word_q;
    logic [7:0] table_read_high_byte_q;
    logic instr_valid_q, fetch_stall, p_o, p_oe_n, d_o, d_oe_n;
    wire p_clk, d_clk, p_in, d_in;
    logic [15:0] ref_mem [logic [12:0]];
    logic [12:0] addrs [10];
    logic [15:0] rd;
    integer seed;
    int errors = 0;
    int checks_done = 0;

    // Only the selected clock moves; a released line shows the inverse of the last bit
    assign p_clk = sclk & ~debug_select;
    assign d_clk = sclk & debug_select;
    assign p_in = !p_oe_n ? p_o : (host_en ? host_bit : ~host_bit);
    assign d_in = !d_oe_n ? d_o : (host_en ? host_bit : ~host_bit);

    core_model #(.ADDR_W(13)) u_core_model (.core_clk(core_clk), .fetch_stall(fetch_stall),
        .pc_addr(pc_addr), .tbl_req(tbl_req));

    program_memory_table_read #(.ADDR_W(13)) u_program_memory_table_read (
        .core_clk(core_clk), .rstn(rstn), .pc_addr(pc_addr), .tbl_req(tbl_req),
        .instr_word_q(instr_word_q), .instr_valid_q(instr_valid_q),
        .fetch_stall(fetch_stall), .dm_wr_q(dm_wr_q),
        .table_read_high_byte_q(table_read_high_byte_q), .serial_enable(serial_enable),
        .debug_select(debug_select), .prog_serial_clock(p_clk), .prog_serial_data_i(p_in),
        .prog_serial_data_o(p_o), .prog_serial_data_oe_n(p_oe_n), .debug_clock_in(d_clk),
        .debug_data_addr_i(d_in), .debug_data_addr_o(d_o), .debug_data_addr_oe_n(d_oe_n));

    // 25 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Reset held for 12 cycles; outputs idle while it is held
    // The first edge makes reset take even if the time-zero fall races the processes
    task automatic hold_reset();
        rstn = 1'b0;
        @(posedge core_clk);
        #1;
        `CHK(instr_valid_q, 1'b0)
        `CHK(fetch_stall, 1'b0)
        `CHK(table_read_high_byte_q, 8'h00)
        `CHK({p_oe_n, d_oe_n}, 2'b11)
        repeat (11) @(posedge core_clk);
        #1 rstn = 1'b1;
    endtask

    // One frame: direction, 13 address bits, 16 data bits, 4 core cycles per phase
    task automatic ser_frame(input logic dbg, input logic rdir, input logic [12:0] a,
            input logic [15:0] wd, output logic [15:0] rdat);
        logic [29:0] fr;
        fr = {rdir, a, wd};
        rdat = '0;
        debug_select = dbg;
        serial_enable = 1'b1;
        for (int i = 0; i < 30; i++) begin
            host_en = !(rdir && i >= 14);
            host_bit = fr[29-i];
            repeat (4) @(posedge core_clk);
            #1 sclk = 1'b1;
            repeat (4) @(posedge core_clk);
            #1 sclk = 1'b0;
            if (rdir && i >= 13 && i <= 28) begin
                rdat[28-i] = dbg ? d_o : p_o;
                `CHK(dbg ? d_oe_n : p_oe_n, 1'b0)
            end
        end
        repeat (6) @(posedge core_clk);
        #1 serial_enable = 1'b0;
        host_en = 1'b1;
        `CHK({p_oe_n, d_oe_n}, 2'b11)
    endtask

    // Table read with the low byte, high byte and two-cycle timing checked
    task automatic tread(input logic cur, input logic [12:0] a, input logic hold);
        logic [31:0] r;
        logic [12:0] pc;
        r = $random(seed);
        pc = cur ? {a[12:8], ~a[7:0]} : r[28:16];
        u_core_model.issue(cur, cur ? ~a[12:8] : a[12:8], a[7:0], r[7:0], pc);
        @(posedge core_clk);
        #1;
        `CHK(fetch_stall, 1'b1)
        `CHK(dm_wr_q.en, 1'b0)
        if (!hold) u_core_model.drop();
        @(posedge core_clk);
        #1;
        if (hold) u_core_model.drop();
        `CHK(dm_wr_q.en, 1'b1)
        `CHK(dm_wr_q.addr, r[7:0])
        `CHK(dm_wr_q.data, ref_mem[a][7:0])
        `CHK(table_read_high_byte_q, ref_mem[a][15:8])
        `CHK(fetch_stall, 1'b0)
        `CHK(instr_valid_q, 1'b0)
        // A held request was dropped just now; let an edge pass before the next one
        if (hold) begin
            @(posedge core_clk);
            #1;
            `CHK(fetch_stall, 1'b0)
            `CHK(dm_wr_q.en, 1'b0)
        end
    endtask

    // Main sequence: preload, reset vector, fetch, table reads, holder stability
    initial begin
        seed = 32'hc232;
        serial_enable = 1'b0;
        debug_select = 1'b0;
        sclk = 1'b0;
        host_bit = 1'b0;
        host_en = 1'b1;
        hold_reset();
        addrs[0] = 13'h0000;
        addrs[1] = 13'h1fff;
        addrs[2] = 13'h0705;
        addrs[3] = 13'h0706;
        for (int i = 4; i < 10; i++) addrs[i] = 13'($random(seed));
        for (int i = 0; i < 10; i++) begin
            ser_frame(i[0], 1'b0, addrs[i], 16'($random(seed)), rd);
            ref_mem[addrs[i]] = 16'($random(seed));
            ser_frame(i[0], 1'b0, addrs[i], ref_mem[addrs[i]], rd);
        end
        for (int i = 0; i < 2; i++) begin
            ser_frame(~i[0], 1'b1, addrs[i], 16'h0000, rd);
            `CHK(rd, ref_mem[addrs[i]])
        end
        u_core_model.set_pc(13'h0abc);
        hold_reset();
        @(posedge core_clk);
        #1;
        `CHK(instr_valid_q, 1'b1)
        `CHK(instr_word_q, ref_mem[13'h0000])
        for (int i = 0; i < 10; i++) begin
            u_core_model.set_pc(addrs[i]);
            @(posedge core_clk);
            #1;
            `CHK(instr_word_q, ref_mem[addrs[i]])
        end
        for (int k = 0; k < 20; k++) tread(k[0] ^ (k >= 10), addrs[k % 10], k % 7 == 3);
        u_core_model.set_pc(13'h0000);
        @(posedge core_clk);
        #1;
        `CHK(instr_valid_q, 1'b1)
        `CHK(instr_word_q, ref_mem[13'h0000])
        ser_frame(1'b0, 1'b1, addrs[3], 16'h0000, rd);
        `CHK(rd, ref_mem[addrs[3]])
        `CHK(table_read_high_byte_q, ref_mem[addrs[9]][15:8])
        complete_run();
    end

    // Watchdog well beyond the expected run of about 5700 cycles
    initial begin
        #(40 * 40000);
        errors++;
        complete_run();
    end
endmodule
